// [core/wdt_pkg.sv]
// constants and carrier types for the watchdog control and reset causes
package wdt_pkg;
  // register offsets in the i/o space; data space adds the shift
  localparam logic [7:0] WDT_CTRL_OFFSET = 8'h21;
  localparam logic [7:0] RESET_CAUSE_OFFSET = 8'h34;
  localparam logic [7:0] DATA_SPACE_SHIFT = 8'h20;
  // reset cause fields
  localparam int SCAN_FLAG_POS = 4;
  localparam int WDOG_FLAG_POS = 3;
  localparam int BROWNOUT_FLAG_POS = 2;
  localparam int PIN_FLAG_POS = 1;
  localparam int POWERON_FLAG_POS = 0;
  localparam logic [4:0] CAUSE_RESET = 5'h01;
  // watchdog control fields
  localparam int UNLOCK_POS = 4;
  localparam int ENABLE_POS = 3;
  localparam int PERIOD_MSB = 2;
  localparam int PERIOD_LSB = 0;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [2:0] PERIOD_RESET = 3'h0;
  // unlock window in processor clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // clock rates; watchdog oscillator becomes an enable pulse
  localparam int CLK_HZ = 40_000_000;
  localparam int WDT_OSC_HZ = 1_000_000;
  localparam int WDT_OSC_DIV = CLK_HZ / WDT_OSC_HZ;
  localparam logic [5:0] OSC_DIV_LAST = 6'(WDT_OSC_DIV - 1);
  // timeout for period code zero, in watchdog oscillator cycles
  localparam int WDT_BASE_CYCLES = 16384;
  localparam int WDT_CNT_W = 22;

  typedef struct packed {
    logic sel_io;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic scan;
    logic brownout;
    logic pin;
  } reset_src_t;
endpackage

// [core/wdt_ctrl.sv]
// watchdog control register, timeout counter and reset cause flags
module wdt_ctrl #(
  parameter int BASE_CYCLES = wdt_pkg::WDT_BASE_CYCLES,
  parameter int OSC_DIV = wdt_pkg::WDT_OSC_DIV
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire wdt_pkg::reg_req_t req,
  input wire wdt_pkg::reset_src_t src,
  input wire logic wdt_kick,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic wdt_reset_pulse,
  output logic wdt_running
);

  localparam int WDT_CNT_W_L = wdt_pkg::WDT_CNT_W;

  // longest limit must still fit the counter
  if (BASE_CYCLES < 1 || (BASE_CYCLES * 128) >= (1 << WDT_CNT_W_L)) begin
    $error("base cycles out of range");
  end
  if (OSC_DIV < 1 || OSC_DIV > 64) begin
    $error("oscillator divider out of range");
  end

  logic [4:0] cause_q;
  logic unlock_q;
  logic [2:0] unlock_cnt_q;
  logic enable_q;
  logic [2:0] period_q;
  logic [5:0] div_q;
  logic tick_q;
  logic [WDT_CNT_W_L-1:0] cnt_q;
  logic wdt_reset_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic chip_reset;
  logic wr_ctrl;
  logic wr_cause;
  logic rd_ctrl;
  logic rd_cause;
  logic [WDT_CNT_W_L-1:0] limit;

  // one decode for both spaces
  function automatic logic hits(wdt_pkg::reg_req_t r, logic [7:0] off);
    logic [7:0] a;
    a = r.sel_io ? off : 8'(off + wdt_pkg::DATA_SPACE_SHIFT);
    return r.addr == a;
  endfunction

  // any non power-on reset source, including our own timeout
  assign chip_reset = src.scan | src.brownout | src.pin | wdt_reset_q;
  assign wr_ctrl = req.wr && !chip_reset &&
                   hits(req, wdt_pkg::WDT_CTRL_OFFSET);
  assign wr_cause = req.wr && hits(req, wdt_pkg::RESET_CAUSE_OFFSET);
  assign rd_ctrl = req.rd && hits(req, wdt_pkg::WDT_CTRL_OFFSET);
  assign rd_cause = req.rd && hits(req, wdt_pkg::RESET_CAUSE_OFFSET);
  assign limit = WDT_CNT_W_L'(BASE_CYCLES) << period_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q[wdt_pkg::SCAN_FLAG_POS] <= 1'b0;
    end else if (src.scan) begin
      cause_q[wdt_pkg::SCAN_FLAG_POS] <= 1'b1;
    end else if (wr_cause && !req.wdata[wdt_pkg::SCAN_FLAG_POS]) begin
      cause_q[wdt_pkg::SCAN_FLAG_POS] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q[wdt_pkg::WDOG_FLAG_POS] <= 1'b0;
    end else if (wdt_reset_q) begin
      cause_q[wdt_pkg::WDOG_FLAG_POS] <= 1'b1;
    end else if (wr_cause && !req.wdata[wdt_pkg::WDOG_FLAG_POS]) begin
      cause_q[wdt_pkg::WDOG_FLAG_POS] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q[wdt_pkg::BROWNOUT_FLAG_POS] <= 1'b0;
    end else if (src.brownout) begin
      cause_q[wdt_pkg::BROWNOUT_FLAG_POS] <= 1'b1;
    end else if (wr_cause && !req.wdata[wdt_pkg::BROWNOUT_FLAG_POS]) begin
      cause_q[wdt_pkg::BROWNOUT_FLAG_POS] <= 1'b0;
    end
  end

  // pin flag set, cleared by write zero or power-on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q[wdt_pkg::PIN_FLAG_POS] <= 1'b0;
    end else if (src.pin) begin
      cause_q[wdt_pkg::PIN_FLAG_POS] <= 1'b1;
    end else if (wr_cause && !req.wdata[wdt_pkg::PIN_FLAG_POS]) begin
      cause_q[wdt_pkg::PIN_FLAG_POS] <= 1'b0;
    end
  end

  // power-on flag set, only software clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q[wdt_pkg::POWERON_FLAG_POS] <=
        wdt_pkg::CAUSE_RESET[wdt_pkg::POWERON_FLAG_POS];
    end else if (wr_cause && !req.wdata[wdt_pkg::POWERON_FLAG_POS]) begin
      cause_q[wdt_pkg::POWERON_FLAG_POS] <= 1'b0;
    end
  end

  // unlock self clears after four cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unlock_q <= wdt_pkg::CTRL_RESET[wdt_pkg::UNLOCK_POS];
      unlock_cnt_q <= 3'h0;
    end else if (chip_reset) begin
      unlock_q <= 1'b0;
      unlock_cnt_q <= 3'h0;
    end else if (wr_ctrl && req.wdata[wdt_pkg::UNLOCK_POS]) begin
      unlock_q <= 1'b1;
      unlock_cnt_q <= wdt_pkg::UNLOCK_CYCLES;
    end else if (unlock_q) begin
      unlock_cnt_q <= unlock_cnt_q - 3'h1;
      if (unlock_cnt_q == 3'h1) begin
        unlock_q <= 1'b0;
      end
    end
  end

  // disable honoured only inside the unlock window
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_q <= wdt_pkg::CTRL_RESET[wdt_pkg::ENABLE_POS];
      period_q <= wdt_pkg::PERIOD_RESET;
    end else if (chip_reset) begin
      enable_q <= 1'b0;
      period_q <= wdt_pkg::PERIOD_RESET;
    end else if (wr_ctrl) begin
      period_q <= req.wdata[wdt_pkg::PERIOD_MSB:wdt_pkg::PERIOD_LSB];
      if (req.wdata[wdt_pkg::ENABLE_POS]) begin
        enable_q <= 1'b1;
      end else if (unlock_q) begin
        enable_q <= 1'b0;
      end
    end
  end

  // oscillator rate as an enable pulse, same clock, no crossing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= 6'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == 6'(OSC_DIV - 1);
      div_q <= (div_q == 6'(OSC_DIV - 1)) ? 6'h0 : div_q + 6'h1;
    end
  end

  // kick restarts, disable and reset clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (chip_reset || !enable_q || wdt_kick) begin
      cnt_q <= '0;
    end else if (tick_q) begin
      // a period cut below the count fires at once, never wraps past
      cnt_q <= (cnt_q >= limit - 1'b1) ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdt_reset_q <= 1'b0;
    end else begin
      wdt_reset_q <= !chip_reset && enable_q && !wdt_kick && tick_q &&
                     cnt_q >= limit - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_ctrl | rd_cause;
      if (rd_ctrl) begin
        rd_data_q <= {3'h0, unlock_q, enable_q, period_q};
      end else if (rd_cause) begin
        rd_data_q <= {3'h0, cause_q};
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign wdt_reset_pulse = wdt_reset_q;
  assign wdt_running = enable_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence unlock_write_s;
    wr_ctrl && req.wdata[wdt_pkg::UNLOCK_POS];
  endsequence
  // no control write and no chip reset for the whole window
  sequence unlock_window_s;
    (!wr_ctrl && !chip_reset) [*4];
  endsequence

  AST_SCAN_FLAG: assert property (src.scan |=> cause_q[4])
    else $error("scan flag not set");
  AST_WDOG_FLAG: assert property (wdt_reset_q |=> cause_q[3])
    else $error("watchdog flag not set");
  AST_BOD_FLAG: assert property (src.brownout |=> cause_q[2])
    else $error("brown-out flag not set");
  AST_PIN_FLAG: assert property (src.pin |=> cause_q[1])
    else $error("pin flag not set");
  AST_FLAG_CLEAR: assert property (
    wr_cause && !req.wdata[1] && !src.pin |=> !cause_q[1])
    else $error("pin flag not cleared by write");
  AST_POR_KEPT: assert property (
    cause_q[0] && !(wr_cause && !req.wdata[0]) |=> cause_q[0])
    else $error("power-on flag lost");
  AST_UNLOCK_FOUR: assert property (
    unlock_write_s ##1 unlock_window_s |-> unlock_q ##1 !unlock_q)
    else $error("unlock window not four cycles");
  AST_UNLOCK_SPAN: assert property (
    unlock_write_s ##1 (!wr_ctrl && !chip_reset) [*5] |->
    $past(unlock_q, 1))
    else $error("unlock cleared early");
  AST_UNLOCK_SEQ: assert property (
    (unlock_write_s and !unlock_q) |=>
    unlock_q && unlock_cnt_q == wdt_pkg::UNLOCK_CYCLES)
    else $error("unlock did not start");
  AST_WDE_LOCK: assert property (
    wr_ctrl && !req.wdata[3] && !unlock_q && enable_q |=> enable_q)
    else $error("enable cleared without unlock");
  AST_WDE_OFF: assert property (
    wr_ctrl && !req.wdata[3] && unlock_q |=> !enable_q)
    else $error("enable not cleared in window");
  AST_KICK: assert property (wdt_kick |=> cnt_q == '0)
    else $error("kick did not restart counter");
  AST_DISABLED: assert property (!enable_q |=> cnt_q == '0)
    else $error("counter runs while disabled");
  AST_TIMEOUT: assert property (
    enable_q && tick_q && !wdt_kick && !chip_reset &&
    cnt_q >= limit - 1'b1 |=> wdt_reset_q ##1 !enable_q)
    else $error("timeout did not reset");
  AST_PULSE_ONE: assert property (wdt_reset_q |=> !wdt_reset_q)
    else $error("reset pulse longer than one cycle");
  AST_RD_UPPER: assert property (
    rd_valid_q |-> rd_data_q[7:5] == 3'h0)
    else $error("upper bits not zero");
  AST_IO_READ: assert property (
    rd_cause |=> rd_valid_q && rd_data_q[4:0] == $past(cause_q))
    else $error("cause read mismatch");
  AST_CTRL_READ: assert property (
    rd_ctrl |=> rd_valid_q && rd_data_q[3] == $past(enable_q) &&
    rd_data_q[2:0] == $past(period_q))
    else $error("control read mismatch");
  AST_WDE_ON: assert property (wr_ctrl && req.wdata[3] |=> enable_q)
    else $error("enable write ignored");
  AST_SCAN_CLEAR: assert property (
    wr_cause && !req.wdata[4] && !src.scan |=> !cause_q[4])
    else $error("scan flag not cleared by write");
  AST_WDOG_CLEAR: assert property (
    wr_cause && !req.wdata[3] && !wdt_reset_q |=> !cause_q[3])
    else $error("watchdog flag not cleared by write");
  AST_BOD_CLEAR: assert property (
    wr_cause && !req.wdata[2] && !src.brownout |=> !cause_q[2])
    else $error("brown-out flag not cleared by write");
  AST_CHIP_CLEAR: assert property (
    chip_reset |=> cnt_q == '0 && !enable_q && !unlock_q)
    else $error("chip reset left watchdog state");

endmodule

// [tb/watchdog_ctrl_and_reset_flags_tb.sv]
// self-checking bench for the watchdog control and reset cause flags
module watchdog_ctrl_and_reset_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts so every period code fits in one run
  localparam int BASE = 4;
  localparam int DIV = 2;
  localparam logic [7:0] CT = wdt_pkg::WDT_CTRL_OFFSET;
  localparam logic [7:0] CS = wdt_pkg::RESET_CAUSE_OFFSET;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wdt_kick = 1'b0;
  wdt_pkg::reg_req_t req = '0;
  wdt_pkg::reset_src_t src = '0;
  logic [7:0] rd_data;
  logic rd_valid;
  logic wdt_reset_pulse;
  logic wdt_running;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pulses = 0;
  int n;

  wdt_ctrl #(.BASE_CYCLES(BASE), .OSC_DIV(DIV)) u_wdt_ctrl (
    .ref_clk(ref_clk),
    .rst(rst),
    .req(req),
    .src(src),
    .wdt_kick(wdt_kick),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .wdt_reset_pulse(wdt_reset_pulse),
    .wdt_running(wdt_running)
  );

  always #12.5 ref_clk = ~ref_clk;

  // counts high cycles, so a stretched pulse shows as an extra count
  always @(negedge ref_clk) begin
    if (wdt_reset_pulse === 1'b1) pulses++;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard well above the longest period sweep
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk8(input logic [7:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %b", $time, m, got);
    end
  endtask

  // one strobe cycle, then one idle cycle before the next access
  task automatic acc(input logic w, io, input logic [7:0] a, d);
    @(negedge ref_clk);
    req.sel_io = io;
    req.addr = io ? a : a + wdt_pkg::DATA_SPACE_SHIFT;
    req.wr = w;
    req.rd = !w;
    req.wdata = d;
    @(negedge ref_clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask

  task automatic wr(input logic io, input logic [7:0] a, d);
    acc(1'b1, io, a, d);
  endtask

  task automatic rd(input logic io, input logic [7:0] a, exp);
    acc(1'b0, io, a, 8'h00);
    chk1(rd_valid, 1'b1, "read valid");
    chk8(rd_data, exp, "read data");
  endtask

  task automatic srcp(input wdt_pkg::reset_src_t s);
    @(negedge ref_clk);
    src = s;
    repeat (2) @(negedge ref_clk);
    src = '0;
  endtask

  task automatic wait_pulse(input int lim);
    n = 0;
    while (wdt_reset_pulse !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    chk1(logic'(n >= lim * DIV - DIV - 1 && n <= lim * DIV + DIV + 2),
         1'b1, "timeout length");
    @(negedge ref_clk);
    chk1(wdt_reset_pulse, 1'b0, "pulse width");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    rd(1'b1, CS, 8'h01);
    rd(1'b0, CT, 8'h00);
    rd(1'b0, CS, 8'h01);
    acc(1'b0, 1'b1, 8'h22, 8'h00);
    chk1(rd_valid, 1'b0, "unmapped read");
    wr(1'b1, CS, 8'hff);
    rd(1'b1, CS, 8'h01);
    wr(1'b0, CT, 8'he8);
    rd(1'b1, CT, 8'h08);
    chk1(wdt_running, 1'b1, "enabled");
    srcp(3'b001);
    rd(1'b1, CT, 8'h00);
    rd(1'b1, CS, 8'h03);
    srcp(3'b010);
    rd(1'b1, CS, 8'h07);
    srcp(3'b100);
    rd(1'b1, CS, 8'h17);
    wr(1'b1, CS, 8'h1e);
    rd(1'b1, CS, 8'h16);
    wr(1'b1, CS, 8'h00);
    rd(1'b1, CS, 8'h00);
    srcp(3'b001);
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    rd(1'b1, CS, 8'h01);
    wr(1'b1, CT, 8'h0b);
    wr(1'b1, CT, 8'h03);
    rd(1'b1, CT, 8'h0b);
    wr(1'b1, CT, 8'h1b);
    rd(1'b1, CT, 8'h1b);
    wr(1'b1, CT, 8'h03);
    rd(1'b1, CT, 8'h03);
    chk1(wdt_running, 1'b0, "disabled");
    wr(1'b1, CT, 8'h0b);
    wr(1'b1, CT, 8'h1b);
    rd(1'b1, CT, 8'h1b);
    rd(1'b1, CT, 8'h1b);
    wr(1'b1, CT, 8'h03);
    rd(1'b1, CT, 8'h0b);
    rd(1'b1, CT, 8'h0b);
    // kick first: the shorter period must not land below the count
    @(negedge ref_clk);
    wdt_kick = 1'b1;
    @(negedge ref_clk);
    wdt_kick = 1'b0;
    wr(1'b1, CT, 8'h09);
    repeat (10) begin
      @(negedge ref_clk);
      wdt_kick = 1'b1;
      @(negedge ref_clk);
      wdt_kick = 1'b0;
      repeat (8) @(negedge ref_clk);
    end
    chk8(8'(pulses), 8'h00, "kicked watchdog fired");
    wr(1'b1, CT, 8'h19);
    wr(1'b1, CT, 8'h01);
    repeat (100) @(negedge ref_clk);
    chk8(8'(pulses), 8'h00, "disabled watchdog fired");
    for (int p = 0; p < 8; p++) begin
      wr(1'b1, CS, 8'h00);
      wr(1'b1, CT, 8'h08 | 8'(p));
      wait_pulse(BASE << p);
      rd(1'b1, CS, 8'h08);
      rd(1'b1, CT, 8'h00);
    end
    chk8(8'(pulses), 8'h08, "pulse count");
    finish_test();
  end
endmodule
